// *** hw/sipg_consts.vh ***
// constants for the system instruction privilege gate
`ifndef SIPG_CONSTS_VH
`define SIPG_CONSTS_VH

// ==========================================
// instruction codes (5-bit)
`define SIPG_OP_LD_GTAB 5'h0_0
`define SIPG_OP_ST_GTAB 5'h0_1
`define SIPG_OP_LD_ITAB 5'h0_2
`define SIPG_OP_ST_ITAB 5'h0_3
`define SIPG_OP_LD_LTAB 5'h0_4
`define SIPG_OP_ST_LTAB 5'h0_5
`define SIPG_OP_LD_TASK 5'h0_6
`define SIPG_OP_ST_TASK 5'h0_7
`define SIPG_OP_CR_RD 5'h0_8
`define SIPG_OP_CR_WR 5'h0_9
`define SIPG_OP_LD_SW 5'h0_a
`define SIPG_OP_ST_SW 5'h0_b
`define SIPG_OP_CLR_TS 5'h0_c
`define SIPG_OP_ADJ_RL 5'h0_d
`define SIPG_OP_LD_AR 5'h0_e
`define SIPG_OP_LD_SL 5'h0_f
`define SIPG_OP_CHK_RD 5'h1_0
`define SIPG_OP_CHK_WR 5'h1_1
`define SIPG_OP_DBG_MV 5'h1_2
`define SIPG_OP_C_DROP 5'h1_3
`define SIPG_OP_C_FLUSH 5'h1_4
`define SIPG_OP_TLB_PG 5'h1_5
`define SIPG_OP_HALT 5'h1_6
`define SIPG_OP_MGMT_X 5'h1_7
`define SIPG_OP_MR_RD 5'h1_8
`define SIPG_OP_MR_WR 5'h1_9
`define SIPG_OP_PERF_RD 5'h1_a
`define SIPG_OP_TSC_RD 5'h1_b
`define SIPG_OP_FP 5'h1_c
`define SIPG_OP_SIMD_FP 5'h1_d
`define SIPG_OP_LOCK 5'h1_e
`define SIPG_OP_FEATQ 5'h1_f

// ==========================================
// field positions
`define SIPG_TS_BIT 3
`define SIPG_TSD_BIT 2
`define SIPG_PCE_BIT 8
`define SIPG_SIMDX_BIT 10
`define SIPG_SW_MSB 15
`define SIPG_THR_MSB 3
`define SIPG_FEATQ_LM_BIT 32

// ==========================================
// control register numbers and reset values
`define SIPG_CR_NUM_PRIO 4'h8
`define SIPG_CR_NUM_MAX 4'h4
`define SIPG_CR_RESET 64'h0000_0000_0000_0000
`define SIPG_THR_RESET 4'h0
`define SIPG_PL_KERNEL 2'h0

`endif

// *** hw/sipg_priv_check.v ***
// privilege and mode check for one decoded system instruction
`timescale 1ns/1ps
`default_nettype none
`include "sipg_consts.vh"

module sipg_priv_check (
    input wire [4:0] i_op,
    input wire [1:0] i_cpl,
    input wire i_long_mode,
    input wire i_tsd,
    input wire i_pce,
    output reg o_gp,
    output reg o_ud
);

wire kernel = (i_cpl == `SIPG_PL_KERNEL);

// ==========================================
// classification
always @* begin
    o_gp = 1'b0;
    o_ud = 1'b0;
    case (i_op)
        `SIPG_OP_LD_GTAB, `SIPG_OP_LD_ITAB, `SIPG_OP_LD_LTAB,
        `SIPG_OP_LD_TASK, `SIPG_OP_CR_RD, `SIPG_OP_CR_WR,
        `SIPG_OP_DBG_MV, `SIPG_OP_LD_SW, `SIPG_OP_CLR_TS,
        `SIPG_OP_C_DROP, `SIPG_OP_C_FLUSH, `SIPG_OP_TLB_PG,
        `SIPG_OP_HALT, `SIPG_OP_MGMT_X, `SIPG_OP_MR_RD,
        `SIPG_OP_MR_WR: begin
            o_gp = !kernel;
        end
        `SIPG_OP_ADJ_RL: begin
            o_ud = i_long_mode;
        end
        `SIPG_OP_TSC_RD: begin
            o_gp = i_tsd && !kernel;
        end
        `SIPG_OP_PERF_RD: begin
            o_gp = !i_pce && !kernel;
        end
        default: begin
            // stores, segment checks, lock prefix: any level
            o_gp = 1'b0;
        end
    endcase
end

endmodule // sipg_priv_check
`default_nettype wire

// *** hw/sipg_gate.v ***
// system instruction decoder with privilege gate and system registers
//
// Behaviour
// - simd exception flag set: unmasked simd fp exception raises simd fault
// - simd exception flag clear: unmasked simd fp exception raises undefined op
// - simd fault comes only from packed simd fp instructions
// - threshold bits 3:0 block priorities up to it; 0 blocks only priority 0, 15 all off
// - priority register reachable only in 64-bit mode, support reported by query
// - table/task loads, control moves and similar run only at level 0
// - table/task stores, status store, segment checks run at any level
// - perf and timestamp reads at level 3 governed by two extended flags
// - adjust requestor level unsupported in 64-bit mode
// - global table load copies base and limit in; store copies them out
// - interrupt table load copies base and limit in; store copies them out
// - local table load takes selector and descriptor; store gives selector
// - task load takes selector and descriptor; store gives selector
// - status word load and store touch bits 15:0 of main control only
// - floating point with task switched flag set raises no device fault
// - clear task switched clears the flag, ending no device faults
// - control move transfers registers 0,1,2,3,4 whole and bits 3:0 of register 8
// - feature query reports each optional extended flag except perf enable
// - task switched flag is bit 3 of main control
// - timestamp-read block flag bit 2 limits timestamp read to level 0
// - perf-enable bit 8 lets perf read run anywhere, else level 0 only
`timescale 1ns/1ps
`default_nettype none
`include "sipg_consts.vh"

module sipg_gate #(
    // implemented optional extended control flags (bit set = present)
    parameter [31:0] EXT_IMPL = 32'h0000_07ff,
    // 64-bit extension present
    parameter [0:0] LONG_SUPPORT = 1'b1
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_valid,
    input wire [4:0] i_op,
    input wire [1:0] i_cpl,
    input wire i_long_mode,
    input wire [3:0] i_cr_num,
    input wire [63:0] i_operand,
    input wire [15:0] i_limit,
    input wire [15:0] i_selector,
    input wire [63:0] i_desc,
    input wire i_simd_exc,
    input wire [3:0] i_irq_prio,
    output reg o_done,
    output reg o_fault_gp,
    output reg o_fault_ud,
    output reg o_fault_nm,
    output reg o_fault_xf,
    output reg [63:0] o_result,
    output reg [15:0] o_result_limit,
    output reg o_irq_pass,
    output reg [63:0] o_main_ctrl,
    output reg [63:0] o_ext_ctrl,
    output reg [3:0] o_task_priority_threshold,
    output reg [63:0] o_global_table_base,
    output reg [15:0] o_global_table_limit,
    output reg [63:0] o_interrupt_table_base,
    output reg [15:0] o_interrupt_table_limit,
    output reg [15:0] o_local_table_sel,
    output reg [63:0] o_local_table_desc,
    output reg [15:0] o_task_sel,
    output reg [63:0] o_task_desc
);

// ==========================================
// control register file: index 0..4, entries 0 and 4 mirrored out
reg [63:0] ctrl_file [0:4];
wire cr_sel_file = (i_cr_num <= `SIPG_CR_NUM_MAX);
wire cr_sel_prio = (i_cr_num == `SIPG_CR_NUM_PRIO);
wire [2:0] cr_idx = i_cr_num[2:0];
// priority register exists only with the extension, in 64-bit mode
wire prio_ok = cr_sel_prio && LONG_SUPPORT && i_long_mode;
wire cr_num_ok = cr_sel_file || prio_ok;

wire ts_flag = ctrl_file[0][`SIPG_TS_BIT];
wire tsd_flag = ctrl_file[4][`SIPG_TSD_BIT];
wire pce_flag = ctrl_file[4][`SIPG_PCE_BIT];
wire simdx_flag = ctrl_file[4][`SIPG_SIMDX_BIT];

// ==========================================
// privilege check
wire chk_gp;
wire chk_ud;

sipg_priv_check u_check (
    .i_op(i_op),
    .i_cpl(i_cpl),
    .i_long_mode(i_long_mode),
    .i_tsd(tsd_flag),
    .i_pce(pce_flag),
    .o_gp(chk_gp),
    .o_ud(chk_ud)
);

wire is_cr = (i_op == `SIPG_OP_CR_RD) || (i_op == `SIPG_OP_CR_WR);
wire is_fp = (i_op == `SIPG_OP_FP) || (i_op == `SIPG_OP_SIMD_FP);

// ==========================================
// fault resolution: protection first, then opcode, then device
reg next_gp;
reg next_ud;
reg next_nm;
reg next_xf;

always @* begin
    next_gp = 1'b0;
    next_ud = 1'b0;
    next_nm = 1'b0;
    next_xf = 1'b0;
    if (i_valid) begin
        if (chk_gp) begin
            next_gp = 1'b1;
        end else if (chk_ud || (is_cr && !cr_num_ok)) begin
            next_ud = 1'b1;
        end else if (is_fp && ts_flag) begin
            next_nm = 1'b1;
        end else if (i_op == `SIPG_OP_SIMD_FP && i_simd_exc) begin
            // only the packed simd class can reach this branch
            next_xf = simdx_flag;
            next_ud = !simdx_flag;
        end
    end
end

wire faulted = next_gp || next_ud || next_nm || next_xf;
wire exec = i_valid && !faulted;

// ==========================================
// result of a store or read
reg [63:0] next_result;
reg [15:0] next_limit;

always @* begin
    next_result = 64'h0000_0000_0000_0000;
    next_limit = 16'h0000;
    case (i_op)
        `SIPG_OP_ST_GTAB: begin
            next_result = o_global_table_base;
            next_limit = o_global_table_limit;
        end
        `SIPG_OP_ST_ITAB: begin
            next_result = o_interrupt_table_base;
            next_limit = o_interrupt_table_limit;
        end
        `SIPG_OP_ST_LTAB: begin
            next_result = {48'h0000_0000_0000, o_local_table_sel};
        end
        `SIPG_OP_ST_TASK: begin
            next_result = {48'h0000_0000_0000, o_task_sel};
        end
        `SIPG_OP_ST_SW: begin
            next_result = {48'h0000_0000_0000,
                ctrl_file[0][`SIPG_SW_MSB:0]};
        end
        `SIPG_OP_CR_RD: begin
            if (cr_sel_prio) begin
                next_result = {60'h00_0000_0000_0000,
                    o_task_priority_threshold};
            end else if (cr_sel_file) begin
                next_result = ctrl_file[cr_idx];
            end
        end
        `SIPG_OP_FEATQ: begin
            // perf enable has no presence report, always shown absent
            next_result[31:0] = EXT_IMPL &
                ~(32'h0000_0001 << `SIPG_PCE_BIT);
            next_result[`SIPG_FEATQ_LM_BIT] = LONG_SUPPORT;
        end
        default: begin
            next_result = 64'h0000_0000_0000_0000;
        end
    endcase
end

// ==========================================
// register updates; a faulted instruction changes nothing
genvar gi;
generate
    for (gi = 0; gi <= 4; gi = gi + 1) begin : g_cr
        always @(posedge i_ref_clk) begin
            if (i_rst) begin
                ctrl_file[gi] <= `SIPG_CR_RESET;
            end else if (exec) begin
                if (i_op == `SIPG_OP_CR_WR && cr_sel_file &&
                    cr_idx == gi) begin
                    ctrl_file[gi] <= i_operand;
                end else if (gi == 0 && i_op == `SIPG_OP_LD_SW) begin
                    ctrl_file[gi][`SIPG_SW_MSB:0] <=
                        i_operand[`SIPG_SW_MSB:0];
                end else if (gi == 0 && i_op == `SIPG_OP_CLR_TS) begin
                    ctrl_file[gi][`SIPG_TS_BIT] <= 1'b0;
                end
            end
        end
    end
endgenerate

// ==========================================
// table and task registers; each loads only on its own instruction
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_global_table_base <= 64'h0000_0000_0000_0000;
        o_global_table_limit <= 16'h0000;
    end else if (exec && i_op == `SIPG_OP_LD_GTAB) begin
        o_global_table_base <= i_operand;
        o_global_table_limit <= i_limit;
    end
end

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_interrupt_table_base <= 64'h0000_0000_0000_0000;
        o_interrupt_table_limit <= 16'h0000;
    end else if (exec && i_op == `SIPG_OP_LD_ITAB) begin
        o_interrupt_table_base <= i_operand;
        o_interrupt_table_limit <= i_limit;
    end
end

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_local_table_sel <= 16'h0000;
        o_local_table_desc <= 64'h0000_0000_0000_0000;
    end else if (exec && i_op == `SIPG_OP_LD_LTAB) begin
        o_local_table_sel <= i_selector;
        o_local_table_desc <= i_desc;
    end
end

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_task_sel <= 16'h0000;
        o_task_desc <= 64'h0000_0000_0000_0000;
    end else if (exec && i_op == `SIPG_OP_LD_TASK) begin
        o_task_sel <= i_selector;
        o_task_desc <= i_desc;
    end
end

// the priority register is written only where it exists in this mode
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_task_priority_threshold <= `SIPG_THR_RESET;
    end else if (exec && i_op == `SIPG_OP_CR_WR && prio_ok) begin
        o_task_priority_threshold <= i_operand[`SIPG_THR_MSB:0];
    end
end

// ==========================================
// answer registers and mirrors
// every answer stands for exactly the one cycle after its request
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_done <= 1'b0;
    end else begin
        o_done <= i_valid;
    end
end

// the priority chain above keeps the four fault flags exclusive
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_fault_gp <= 1'b0;
    end else begin
        o_fault_gp <= next_gp;
    end
end

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_fault_ud <= 1'b0;
    end else begin
        o_fault_ud <= next_ud;
    end
end

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_fault_nm <= 1'b0;
    end else begin
        o_fault_nm <= next_nm;
    end
end

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_fault_xf <= 1'b0;
    end else begin
        o_fault_xf <= next_xf;
    end
end

// a faulted request returns zero so no stale data leaks out
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_result <= 64'h0000_0000_0000_0000;
    end else begin
        o_result <= exec ? next_result : 64'h0000_0000_0000_0000;
    end
end

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_result_limit <= 16'h0000;
    end else begin
        o_result_limit <= exec ? next_limit : 16'h0000;
    end
end

// a class passes only above the threshold; 15 blocks all
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_irq_pass <= 1'b0;
    end else begin
        o_irq_pass <= (i_irq_prio > o_task_priority_threshold);
    end
end

// mirrors lag the internal file by one cycle to stay flop-driven
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_main_ctrl <= `SIPG_CR_RESET;
    end else begin
        o_main_ctrl <= ctrl_file[0];
    end
end

always @(posedge i_ref_clk) begin
    if (i_rst) begin
        o_ext_ctrl <= `SIPG_CR_RESET;
    end else begin
        o_ext_ctrl <= ctrl_file[4];
    end
end

endmodule // sipg_gate
`default_nettype wire

// *** verification/sipg_gate_monitor.sv ***
// assertions on the instruction gate ports
`timescale 1ns/1ps
`default_nettype none
`include "sipg_consts.vh"
module sipg_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic [4:0] i_op,
    input wire logic [1:0] i_cpl,
    input wire logic i_long_mode,
    input wire logic i_simd_exc,
    input wire logic o_done,
    input wire logic o_fault_gp,
    input wire logic o_fault_ud,
    input wire logic o_fault_nm,
    input wire logic o_fault_xf,
    input wire logic [63:0] o_main_ctrl,
    input wire logic [63:0] o_ext_ctrl
);
    // ==========================================
    // helpers
    wire logic user = i_valid && i_cpl != 2'h0;
    wire logic [3:0] flt = {o_fault_gp, o_fault_ud, o_fault_nm, o_fault_xf};
    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // ==========================================
    // properties
    AST_DONE: assert property (1'b1 |=> o_done == $past(i_valid))
        else $error("done does not follow request");
    AST_FLT: assert property (flt != 4'h0
        |-> o_done && $onehot0(flt))
        else $error("fault without done or several faults");
    AST_PRIV: assert property (user && i_op inside {`SIPG_OP_LD_GTAB,
        `SIPG_OP_LD_TASK, `SIPG_OP_CR_WR, `SIPG_OP_CLR_TS, `SIPG_OP_HALT}
        |=> o_fault_gp) else $error("privileged op not refused");
    AST_TSC: assert property (user && i_op == `SIPG_OP_TSC_RD
        |=> o_fault_gp == o_ext_ctrl[2]) else $error("timestamp gate");
    AST_PERF: assert property (user && i_op == `SIPG_OP_PERF_RD
        |=> o_fault_gp == !o_ext_ctrl[8]) else $error("perf gate");
    AST_ADJ: assert property (i_valid && i_op == `SIPG_OP_ADJ_RL
        && i_long_mode |=> o_fault_ud) else $error("adjust in long mode");
    AST_NM: assert property (i_valid && i_op == `SIPG_OP_FP
        |=> o_fault_nm == o_main_ctrl[3]) else $error("no device fault");
    AST_XF: assert property (i_valid && i_op == `SIPG_OP_SIMD_FP
        && i_simd_exc |=> o_main_ctrl[3] || (o_fault_xf == o_ext_ctrl[10]
        && o_fault_ud != o_ext_ctrl[10])) else $error("simd fault kind");
    AST_XF_SRC: assert property (o_fault_xf |->
        $past(i_op) == `SIPG_OP_SIMD_FP) else $error("simd fault source");
endmodule // sipg_monitor

bind sipg_gate sipg_monitor u_mon (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_valid(i_valid), .i_op(i_op),
    .i_cpl(i_cpl), .i_long_mode(i_long_mode), .i_simd_exc(i_simd_exc),
    .o_done(o_done), .o_fault_gp(o_fault_gp), .o_fault_ud(o_fault_ud),
    .o_fault_nm(o_fault_nm), .o_fault_xf(o_fault_xf),
    .o_main_ctrl(o_main_ctrl), .o_ext_ctrl(o_ext_ctrl)
);
`default_nettype wire

// *** verification/tb_sipg_gate.sv ***
// self-checking bench for the instruction privilege gate
`timescale 1ns/1ps
`default_nettype none
`include "sipg_consts.vh"
module tb_sipg_gate;
    localparam logic [31:0] EXT = 32'h0000_07ff;
    logic i_ref_clk, i_rst, i_valid, i_long_mode, i_simd_exc, o_irq_pass;
    logic o_done, o_fault_gp, o_fault_ud, o_fault_nm, o_fault_xf;
    logic [1:0] i_cpl;
    logic [4:0] i_op;
    logic [3:0] i_cr_num, i_irq_prio, o_task_priority_threshold, thr, t;
    logic [15:0] i_limit, i_selector, o_result_limit, o_global_table_limit;
    logic [15:0] o_interrupt_table_limit, o_local_table_sel, o_task_sel;
    logic [15:0] gl, il, ls, tks;
    logic [63:0] i_operand, i_desc, o_result, o_main_ctrl, o_ext_ctrl;
    logic [63:0] o_global_table_base, o_interrupt_table_base, gb, ib, ld, td;
    logic [63:0] o_local_table_desc, o_task_desc;
    logic [63:0] cr [0:4];
    int mismatches = 0;
    int total_checks = 0;

    sipg_gate #(.EXT_IMPL(EXT)) DUT (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_valid(i_valid),
        .i_op(i_op), .i_cpl(i_cpl), .i_long_mode(i_long_mode),
        .i_cr_num(i_cr_num), .i_operand(i_operand), .i_limit(i_limit),
        .i_selector(i_selector), .i_desc(i_desc), .i_simd_exc(i_simd_exc),
        .i_irq_prio(i_irq_prio), .o_done(o_done), .o_fault_gp(o_fault_gp),
        .o_fault_ud(o_fault_ud), .o_fault_nm(o_fault_nm),
        .o_fault_xf(o_fault_xf), .o_result(o_result),
        .o_result_limit(o_result_limit), .o_irq_pass(o_irq_pass),
        .o_main_ctrl(o_main_ctrl), .o_ext_ctrl(o_ext_ctrl),
        .o_task_priority_threshold(o_task_priority_threshold),
        .o_global_table_base(o_global_table_base),
        .o_global_table_limit(o_global_table_limit),
        .o_interrupt_table_base(o_interrupt_table_base),
        .o_interrupt_table_limit(o_interrupt_table_limit),
        .o_local_table_sel(o_local_table_sel),
        .o_local_table_desc(o_local_table_desc),
        .o_task_sel(o_task_sel), .o_task_desc(o_task_desc)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input string nm, input logic [63:0] exp, seen);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================
    // one instruction a cycle; the mirrors lag, so they show the old state
    task automatic step(input logic v, input logic [4:0] op,
            input logic [1:0] cpl, input logic lm, input logic [3:0] n,
            input logic [63:0] d, input logic x);
        logic [63:0] m0, m4, r;
        logic [3:0] f;
        logic p;
        m0 = cr[0];
        m4 = cr[4];
        f = 4'h0;
        r = 64'h0;
        {i_valid, i_op, i_cpl, i_long_mode, i_cr_num} = {v, op, cpl, lm, n};
        {i_operand, i_simd_exc} = {d, x};
        {i_limit, i_selector} = $urandom;
        i_desc = {$urandom, $urandom};
        p = op inside {`SIPG_OP_LD_GTAB, `SIPG_OP_LD_ITAB, `SIPG_OP_LD_LTAB,
            `SIPG_OP_LD_TASK, `SIPG_OP_CR_RD, `SIPG_OP_CR_WR, `SIPG_OP_LD_SW,
            `SIPG_OP_CLR_TS, `SIPG_OP_DBG_MV, `SIPG_OP_C_DROP, `SIPG_OP_HALT,
            `SIPG_OP_C_FLUSH, `SIPG_OP_TLB_PG, `SIPG_OP_MGMT_X,
            `SIPG_OP_MR_RD, `SIPG_OP_MR_WR};
        if (!v)
            f = 4'h0;
        else if (cpl != 2'h0 && (p || (op == `SIPG_OP_TSC_RD && m4[2])
                || (op == `SIPG_OP_PERF_RD && !m4[8])))
            f = 4'h8;
        else if ((op == `SIPG_OP_ADJ_RL && lm)
                || (op inside {`SIPG_OP_CR_RD, `SIPG_OP_CR_WR}
                && !(n <= 4'h4 || (n == 4'h8 && lm))))
            f = 4'h4;
        else if (op inside {`SIPG_OP_FP, `SIPG_OP_SIMD_FP} && m0[3])
            f = 4'h2;
        else if (op == `SIPG_OP_SIMD_FP && x)
            f = m4[10] ? 4'h1 : 4'h4;
        else
            case (op)
            `SIPG_OP_LD_GTAB: {gb, gl} = {d, i_limit};
            `SIPG_OP_ST_GTAB: r = gb;
            `SIPG_OP_LD_ITAB: {ib, il} = {d, i_limit};
            `SIPG_OP_ST_ITAB: r = ib;
            `SIPG_OP_LD_LTAB: {ls, ld} = {i_selector, i_desc};
            `SIPG_OP_ST_LTAB: r = {48'h0, ls};
            `SIPG_OP_LD_TASK: {tks, td} = {i_selector, i_desc};
            `SIPG_OP_ST_TASK: r = {48'h0, tks};
            `SIPG_OP_CR_RD: r = n[3] ? {60'h0, thr} : cr[n[2:0]];
            `SIPG_OP_CR_WR: begin
                if (n[3])
                    thr = d[3:0];
                else
                    cr[n[2:0]] = d;
            end
            `SIPG_OP_LD_SW: cr[0][15:0] = d[15:0];
            `SIPG_OP_ST_SW: r = {48'h0, m0[15:0]};
            `SIPG_OP_CLR_TS: cr[0][3] = 1'b0;
            `SIPG_OP_FEATQ: r = {32'h0000_0001, EXT & ~32'h0000_0100};
            default: r = 64'h0;
            endcase
        @(posedge i_ref_clk);
        #1;
        chk("done", {63'h0, v}, {63'h0, o_done});
        chk("fault", {60'h0, f}, {60'h0, o_fault_gp, o_fault_ud,
            o_fault_nm, o_fault_xf});
        if (v && !(f == 4'h0 && op inside {`SIPG_OP_TSC_RD,
                `SIPG_OP_PERF_RD, `SIPG_OP_MR_RD, `SIPG_OP_DBG_MV}))
            chk("result", r, o_result);
        if (v && f == 4'h0 && op inside {`SIPG_OP_ST_GTAB, `SIPG_OP_ST_ITAB})
            chk("limit", {48'h0, op[1] ? il : gl}, {48'h0, o_result_limit});
        chk("gbase", gb, o_global_table_base);
        chk("ibase", ib, o_interrupt_table_base);
        chk("ldesc", ld, o_local_table_desc);
        chk("tdesc", td, o_task_desc);
        chk("sel_lim", {gl, il, ls, tks}, {o_global_table_limit,
            o_interrupt_table_limit, o_local_table_sel, o_task_sel});
        chk("thr", {60'h0, thr}, {60'h0, o_task_priority_threshold});
        chk("main", m0, o_main_ctrl);
        chk("ext", m4, o_ext_ctrl);
        #1;
    endtask

    task automatic go(input logic [4:0] op, input logic [1:0] cpl,
            input logic [63:0] d);
        step(1'b1, op, cpl, 1'b0, 4'h0, d, 1'b1);
    endtask

    // ==========================================
    // main sequence
    initial begin
        i_rst = 1'b1;
        {i_valid, i_op, i_cpl, i_long_mode, i_cr_num, i_irq_prio} = '0;
        {i_operand, i_desc, i_limit, i_selector, i_simd_exc} = '0;
        {gb, ib, ld, td, gl, il, ls, tks, thr} = '0;
        foreach (cr[i])
            cr[i] = 64'h0;
        void'($urandom(99233));
        repeat (12)
            @(posedge i_ref_clk);
        #2;
        i_rst = 1'b0;
        step(1'b0, 5'h0, 2'h0, 1'b0, 4'h0, 64'h0, 1'b0);
        $display("test reset done");
        go(`SIPG_OP_CR_WR, 2'h0, '1);
        go(`SIPG_OP_FP, 2'h3, 64'h0);
        go(`SIPG_OP_LD_SW, 2'h0, 64'h0000_0000_0000_0008);
        go(`SIPG_OP_ST_SW, 2'h3, 64'h0);
        go(`SIPG_OP_SIMD_FP, 2'h0, 64'h0);
        go(`SIPG_OP_CLR_TS, 2'h3, 64'h0);
        go(`SIPG_OP_CLR_TS, 2'h0, 64'h0);
        go(`SIPG_OP_SIMD_FP, 2'h3, 64'h0);
        $display("test task switch done");
        repeat (400)
            step($urandom_range(0, 7) != 0, 5'($urandom),
                $urandom_range(0, 1) ? 2'h0 : 2'($urandom), 1'($urandom),
                $urandom_range(0, 1) ? 4'($urandom_range(0, 4)) : 4'($urandom),
                {$urandom, $urandom}, 1'($urandom));
        $display("test random done");
        for (int k = 0; k < 3; k++) begin
            t = k == 0 ? 4'h0 : k == 1 ? 4'hf : 4'($urandom_range(1, 14));
            step(1'b1, `SIPG_OP_CR_WR, 2'h0, 1'b1, 4'h8, {60'h0, t}, 1'b0);
            step(1'b0, 5'h0, 2'h0, 1'b0, 4'h0, 64'h0, 1'b0);
            for (int p = 0; p < 16; p++) begin
                i_irq_prio = 4'(p);
                // pass flag is registered from the previous cycle's compare
                repeat (2)
                    @(posedge i_ref_clk);
                #1;
                chk("irq", {63'h0, p > t}, {63'h0, o_irq_pass});
                #1;
            end
        end
        $display("test threshold done");
        test_done();
    end

    initial begin
        repeat (20000)
            @(posedge i_ref_clk);
        mismatches++;
        $display("CHECK FAILED watchdog expected end seen hang");
        test_done();
    end
endmodule // tb_sipg_gate
`default_nettype wire
